// ### pkg/scanline_pkg.sv
// Purpose: shared constants for the scan-line sync and line counter block
// Assumes: one machine cycle per ref_clk rising edge
// Notes: offsets are host bus byte addresses
package scanline_pkg;
	// ==========================================
	// register map
	localparam logic [15:0] line_sync_strobe_addr = 16'hD40A;
	localparam logic [15:0] vertical_line_readout_addr = 16'hD40B;
	// ==========================================
	// horizontal timing
	localparam int cycles_per_line = 114;
	localparam logic [6:0] last_cycle = 7'h71;
	localparam logic [6:0] strobe_deadline = 7'h67;
	localparam logic [6:0] release_cycle = 7'h69;
	localparam logic [6:0] increment_cycle = 7'h6E;
	// ==========================================
	// vertical timing and counter reset values
	localparam logic [8:0] last_line_60hz = 9'h105;
	localparam logic [8:0] last_line_50hz = 9'h137;
	localparam logic [8:0] line_reset_value = 9'h000;
	localparam logic [6:0] hcount_reset_value = 7'h00;
endpackage : scanline_pkg

// ### core/line_counter.sv
// Purpose: vertical scan counter with delayed end-of-frame reset
// Assumes: hcount supplied by the parent
// Notes: readout drops bit 0 of the counter
module line_counter (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// timing
	input wire logic [6:0] hcount,
	input wire logic mode_50hz,
	// readout
	output logic [7:0] readout
);
	logic [8:0] vertical_line_readout;
	logic at_inc;
	logic at_end;
	logic past_end;
	logic [8:0] last_line;
	// step one edge early so the new value stands during the increment cycle
	assign at_inc = (hcount == scanline_pkg::increment_cycle - 7'h01);
	assign last_line = mode_50hz ? scanline_pkg::last_line_50hz : scanline_pkg::last_line_60hz;
	assign at_end = (vertical_line_readout > last_line);
	// one extra cycle before the wrap shows
	assign past_end = at_end && (hcount == scanline_pkg::increment_cycle);
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			vertical_line_readout <= scanline_pkg::line_reset_value;
		end else if (past_end) begin
			vertical_line_readout <= scanline_pkg::line_reset_value;
		end else if (at_inc) begin
			vertical_line_readout <= vertical_line_readout + 9'h001;
		end
	end
	assign readout = vertical_line_readout[8:1];
endmodule : line_counter

// ### core/scanline_sync.sv
// Purpose: line sync strobe hold of the host ready line, and line readout
// Assumes: host ignores ready hold on its write cycles
// Notes: dma occupancy of cycles 105 and 106 comes from the dma scheduler
//
// Functional notes
// - strobe write holds host ready after one cycle until cycle 105
// - writes by cycle 103 release this line; 104 or later the next line
// - playfield dma on cycle 105 delays release by one cycle
// - refresh on 105 delays one; refresh pushed to 106 delays two
// - last rmw write to strobe must arrive by cycle 103
// - rmw writes on 103 and 104 hold next fetch to next line 105
// - readout returns vertical counter bits 1 through 8
// - readout holds through cycle 109, increments on 110
// - readout wraps after 0x82 at 60 Hz, 0x9B at 50 Hz
// - final line shows 0x83 or 0x9C on 110 only, zero from 111
module scanline_sync (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// host bus
	input wire logic [15:0] addr,
	input wire logic write_en,
	input wire logic read_en,
	output logic [7:0] read_data,
	output logic ready,
	// dma occupancy and mode
	input wire logic playfield_dma_105,
	input wire logic refresh_dma_105,
	input wire logic mode_50hz,
	// horizontal position
	output logic [6:0] hcount
);
	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_arm = 4'b0010,
		st_hold = 4'b0100,
		st_slip = 4'b1000
	} sync_state_e;

	// ==========================================
	// state and control signals
	sync_state_e state;
	sync_state_e next_state;

	logic next_line;
	logic strobe_wr;
	logic strobe_taken;

	logic [1:0] slip;
	logic [1:0] next_slip;
	logic [1:0] slip_need;
	logic slip_last;

	logic line_end;
	logic at_release;
	logic late_write;
	logic hold_active;
	logic release_now;

	logic wait_line;
	logic next_wait_line;

	logic [6:0] next_hcount;

	logic readout_sel;
	logic [7:0] readout;
	logic [7:0] next_read_data;

	// ==========================================
	// horizontal counter
	assign line_end = (hcount == scanline_pkg::last_cycle);

	assign next_hcount = line_end ? scanline_pkg::hcount_reset_value
		: hcount + 7'h01;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hcount <= scanline_pkg::hcount_reset_value;
		end else begin
			hcount <= next_hcount;
		end
	end

	// ==========================================
	// strobe decode
	assign strobe_wr = write_en && (addr == scanline_pkg::line_sync_strobe_addr);

	// a strobe counts only while the host still runs
	assign strobe_taken = strobe_wr && ready;

	// a write on the last cycle reaches the next release anyway
	assign late_write = (hcount > scanline_pkg::strobe_deadline)
		&& !line_end;

	// ==========================================
	// release timing
	assign at_release = (hcount == scanline_pkg::release_cycle);

	assign hold_active = (state == st_hold);

	assign release_now = hold_active && at_release && !wait_line;

	// refresh pushed to 106 by playfield gives two cycles
	assign slip_need = playfield_dma_105 ? (refresh_dma_105 ? 2'h2 : 2'h1)
		: (refresh_dma_105 ? 2'h1 : 2'h0);

	assign slip_last = (slip == 2'h1);

	// ==========================================
	// late write flag
	// the strobe wins over the line end clear
	assign next_wait_line = strobe_taken ? next_line
		: (line_end ? 1'b0 : wait_line);

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wait_line <= 1'b0;
		end else begin
			wait_line <= next_wait_line;
		end
	end

	// ==========================================
	// hold state machine
	always_comb begin
		next_state = state;
		next_line = 1'b0;
		next_slip = slip;
		unique case (state)
			st_idle: begin
				if (strobe_wr) begin
					next_state = st_arm;
					next_line = late_write;
				end
			end
			st_arm: begin
				if (strobe_wr) begin
					// second rmw write restarts the grace cycle
					next_state = st_arm;
					next_line = late_write;
				end else begin
					// hold starts one cycle after the last write
					next_state = st_hold;
				end
			end
			st_hold: begin
				if (release_now) begin
					next_slip = slip_need;
					if (slip_need == 2'h0) begin
						next_state = st_idle;
					end else begin
						next_state = st_slip;
					end
				end
			end
			st_slip: begin
				next_slip = slip - 2'h1;
				if (slip_last) begin
					next_state = st_idle;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state <= st_idle;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			slip <= 2'h0;
		end else begin
			slip <= next_slip;
		end
	end

	// ==========================================
	// host ready
	// host repeats its read while low; writes pass regardless
	assign ready = (state == st_idle) || (state == st_arm);

	// ==========================================
	// line counter readout
	line_counter u_line_counter (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.hcount(hcount),
		.mode_50hz(mode_50hz),
		.readout(readout)
	);

	// ==========================================
	// read data register
	assign readout_sel = read_en && (addr == scanline_pkg::vertical_line_readout_addr);

	// unmapped reads leave the last value standing
	assign next_read_data = readout_sel ? readout : read_data;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			read_data <= 8'h00;
		end else begin
			read_data <= next_read_data;
		end
	end
endmodule : scanline_sync

// ### verif/host_model.sv
// Purpose: host core model; Assumes: ref_clk; Notes: reads wait for ready
module host_model (
	// bus
	input wire logic ref_clk,
	input wire logic ready,
	output logic [15:0] addr = 16'h0000,
	output logic write_en = 1'b0,
	output logic read_en = 1'b0
);
	timeunit 1ns / 1ns;
	int n;
	task cyc(input logic [15:0] a, input logic w);
		logic r;
		@(negedge ref_clk);
		addr = a;
		write_en = w;
		read_en = !w;
		r = ready;
		@(posedge ref_clk);
		while (!w && !r) begin
			n++;
			@(negedge ref_clk);
			r = ready;
			@(posedge ref_clk);
		end
	endtask : cyc
endmodule : host_model

// ### verif/scanline_sync_checker.sv
// Purpose: port checks; Assumes: one clock; Notes: bound below
module scanline_sync_checker (
	// bus and timing
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [15:0] addr,
	input wire logic write_en,
	input wire logic read_en,
	input wire logic [7:0] read_data,
	input wire logic ready,
	input wire logic [6:0] hcount
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire st = write_en && addr == 16'hD40A;
	wire rd = read_en && addr == 16'hD40B;
	property p_wr; hcount == 7'h71 |=> hcount == 7'h00; endproperty
	a_wr: assert property (p_wr) else $error("wrap");
	property p_ar; st && ready && hcount <= 7'h67 ##1 !st |-> ready ##1 !ready; endproperty
	a_ar: assert property (p_ar) else $error("arm");
	property p_ca; $fell(ready) |-> $past(st, 2); endproperty
	a_ca: assert property (p_ca) else $error("cause");
	property p_wn; $rose(ready) |-> hcount inside {[7'h6A:7'h6C]}; endproperty
	a_wn: assert property (p_wn) else $error("window");
	property p_bd; $fell(ready) |-> ##[1:230] ready; endproperty
	a_bd: assert property (p_bd) else $error("stuck");
	property p_lt; st && ready && !$past(st) && hcount == 7'h68 |-> ##2 !ready [*8]; endproperty
	a_lt: assert property (p_lt) else $error("late");
	property p_hd; !rd |=> $stable(read_data); endproperty
	a_hd: assert property (p_hd) else $error("hold");
	property p_hl; rd && $past(rd) && hcount inside {[7'h01:7'h6D]} |=> $stable(read_data); endproperty
	a_hl: assert property (p_hl) else $error("early");
	c_st: cover property (st && ready);
	c_sl: cover property ($rose(ready) && hcount == 7'h6C);
	c_fr: cover property (rd && hcount == 7'h70 && read_data == 8'h00);
endmodule : scanline_sync_checker
bind scanline_sync scanline_sync_checker scanline_sync_checker_inst (.ref_clk, .reset_n, .addr,
	.write_en, .read_en, .read_data, .ready, .hcount);

// ### verif/scanline_sync_tb.sv
// Purpose: bench; Assumes: host_model on bus; Notes: frames, then strobes
module scanline_sync_tb;
	timeunit 1ns / 1ns;
	logic ref_clk = 1'b0, reset_n = 1'b0, pf = 1'b0, rf = 1'b0, mode_50hz = 1'b0;
	logic ready, write_en, read_en;
	logic [15:0] addr;
	logic [7:0] read_data;
	logic [6:0] hcount;
	int errors, check_count, cycles;
	scanline_sync scanline_sync_inst (.ref_clk, .reset_n, .addr, .write_en, .read_en, .read_data,
		.ready, .playfield_dma_105(pf), .refresh_dma_105(rf), .mode_50hz, .hcount);
	host_model host_model_inst (.ref_clk, .ready, .addr, .write_en, .read_en);
	initial forever #50 ref_clk = !ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 80000) begin
			errors++;
			complete_run;
		end
	end
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task complete_run;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task frame(input logic m, input int last);
		int e;
		for (int l = 0; l <= last; l++) begin
			do @(negedge ref_clk); while (hcount !== 7'h6B);
			mode_50hz = m;
			for (int j = 0; j < 4; j++) begin
				host_model_inst.cyc(16'hD40B, 1'b0);
				e = j < 2 ? l / 2 : (j == 3 && l == last) ? 0 : (l + 1) / 2;
				#1 chk("line", 8'(e), read_data);
			end
		end
	endtask : frame
	task sync(input logic [6:0] h, input logic [2:0] f, input int e);
		do @(negedge ref_clk); while (hcount !== h - 7'h01);
		pf = f[2];
		rf = f[1];
		host_model_inst.n = 0;
		host_model_inst.cyc(16'hD40A, 1'b1);
		if (f[0])
			host_model_inst.cyc(16'hD40A, 1'b1);
		repeat (2) host_model_inst.cyc(16'h0000, 1'b0);
		chk("stall", 8'(e), 8'(host_model_inst.n));
	endtask : sync
	initial begin
		repeat (4) @(negedge ref_clk);
		reset_n = 1'b1;
		frame(1'b0, 261);
		frame(1'b1, 311);
		host_model_inst.cyc(16'hD40C, 1'b0);
		#1 chk("unmapped", 8'h00, read_data);
		sync(7'h32, 3'b000, 54);
		sync(7'h67, 3'b000, 1);
		sync(7'h68, 3'b000, 114);
		sync(7'h67, 3'b100, 2);
		sync(7'h67, 3'b010, 2);
		sync(7'h67, 3'b110, 3);
		sync(7'h66, 3'b001, 1);
		sync(7'h67, 3'b001, 114);
		complete_run;
	end
endmodule : scanline_sync_tb
